// ### move_or_cond_return_exec.sv
// Purpose: executes loads, stores, moves, or, or_with_accumulator and conditional_return
// Assumes: apb slave, data memory master port with one-cycle handshake done per t-state
// Notes:   one t-state is one enabled pclk cycle; the register file is internal
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module move_or_cond_return_exec #(
	parameter int STACK_DEPTH = 8,
	parameter int TXPORT_REG  = 5'd31
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_wr,
	output logic             mem_rd,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        receiver_active_flag,
	input  wire logic        line_error_flag,
	input  wire logic        receive_byte_ready,
	input  wire logic        transmit_queue_full,
	output logic             tx_push,
	output logic [10:0]      tx_word,
	output logic [7:0]       irq_mask_control,
	output logic             global_irq_gate
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [15:0] idx_sum(input logic [15:0] base, input logic [7:0] off);
		idx_sum = base + {8'h00, off};
	endfunction : idx_sum

	function automatic exec_pkg::alu_flags_s nz_flags(input exec_pkg::alu_flags_s f, input logic [7:0] r);
		nz_flags   = f;
		nz_flags.n = r[7];
		nz_flags.z = (r == 8'h00);
	endfunction : nz_flags

	// ----------------------------------------
	// state
	// ----------------------------------------
	exec_pkg::exec_state_e  state_reg, state_next;
	exec_pkg::cmd_s         cmd_reg, cmd_next;
	exec_pkg::opnd_s        opnd_reg, opnd_next;
	exec_pkg::alu_flags_s   flags_reg, flags_next;
	logic [15:0]            ptr_reg [3], ptr_next [3];
	logic [15:0]            pc_reg, pc_next;
	logic                   gate_reg, gate_next;
	logic [3:0]             bank_reg, bank_next;
	logic [7:0]             cfg_reg, cfg_next;
	logic [7:0]             irqm_reg, irqm_next;
	logic [2:0]             txhi_reg, txhi_next;
	logic [2:0]             tcnt_reg, tcnt_next;
	logic [2:0]             tlen_reg, tlen_next;
	exec_pkg::stack_entry_s stk_reg [STACK_DEPTH], stk_next [STACK_DEPTH];
	logic [3:0]             sp_reg, sp_next;
	logic [31:0]            prdata_next;
	logic                   pready_next, pslverr_next;
	logic [15:0]            maddr_next;
	logic [7:0]             mwdata_next;
	logic                   mwr_next, mrd_next, txp_next;
	logic [10:0]            txw_next;

	// register file, read port a = source, b = accumulator (register 0)
	logic        rf_we;
	logic [4:0]  rf_waddr, rf_raddr;
	logic [7:0]  rf_wdata, src_val, acc_val;

	exec_regfile #(.DEPTH(32), .AW(5)) u_regs (
		.pclk    (pclk),
		.ce      (ce),
		.we      (rf_we),
		.waddr   (rf_waddr),
		.wdata   (rf_wdata),
		.raddr_a (rf_raddr),
		.raddr_b (5'h00),
		.rdata_a (src_val),
		.rdata_b (acc_val)
	);

	// pin-side flags, two flops before use
	logic [3:0] pin_s1, pin_s2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end else if (ce) begin
			pin_s1 <= {transmit_queue_full, receive_byte_ready, line_error_flag, receiver_active_flag};
			pin_s2 <= pin_s1;
		end
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	logic [7:0]  flag_vec;
	logic        cond_true;
	logic [1:0]  psel_i;
	logic [15:0] ptr_sel_val, ptr_inc, eff_addr;
	logic        is_write, is_read, apb_acc;
	exec_pkg::stack_entry_s top;

	always_comb begin
		flag_vec  = {pin_s2, flags_reg.n, flags_reg.v, flags_reg.c, flags_reg.z};
		cond_true = (flag_vec[cmd_reg.flag_sel] == cmd_reg.flag_level);
		psel_i    = (cmd_reg.ptr_sel == 2'b00) ? 2'd0 : 2'(cmd_reg.ptr_sel - 2'd1);
		ptr_sel_val = ptr_reg[psel_i];
		ptr_inc   = idx_sum(ptr_sel_val, 8'h01);
		unique case (exec_pkg::addr_mode_e'(cmd_reg.amode))
			exec_pkg::AM_PTR_ACC:  eff_addr = idx_sum(ptr_sel_val, acc_val);
			exec_pkg::AM_PTR3_IMM: eff_addr = idx_sum(ptr_reg[2], opnd_reg.imm);
			exec_pkg::AM_PTR_UPD:  eff_addr = (cmd_reg.upd == exec_pkg::UPD_PRE) ? ptr_inc : ptr_sel_val;
			exec_pkg::AM_REG:      eff_addr = ptr_sel_val;
		endcase
		apb_acc  = psel && penable && !pready;
		is_write = apb_acc && pwrite;
		is_read  = apb_acc && !pwrite;
		top      = stk_reg[3'(sp_reg - 4'd1)];
		// idle: bus reads the file; busy: the operand that the instruction needs
		if (state_reg == exec_pkg::ST_IDLE) begin
			rf_raddr = 5'((paddr - exec_pkg::REG_BASE_OFS) >> 2);
		end else if (cmd_reg.opcode == exec_pkg::OP_OR_IMM) begin
			rf_raddr = {1'b0, opnd_reg.dst[3:0]};
		end else if (cmd_reg.opcode == exec_pkg::OP_MOVE_REG && cmd_reg.dst_mem &&
			cmd_reg.amode == exec_pkg::AM_PTR3_IMM) begin
			rf_raddr = {1'b0, opnd_reg.src[3:0]};
		end else begin
			rf_raddr = opnd_reg.src;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cmd_next   = cmd_reg;
		opnd_next  = opnd_reg;
		flags_next = flags_reg;
		ptr_next   = ptr_reg;
		pc_next    = pc_reg;
		gate_next  = gate_reg;
		bank_next  = bank_reg;
		cfg_next   = cfg_reg;
		irqm_next  = irqm_reg;
		txhi_next  = txhi_reg;
		tcnt_next  = tcnt_reg;
		tlen_next  = tlen_reg;
		stk_next   = stk_reg;
		sp_next    = sp_reg;
		prdata_next  = 32'h0000_0000;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		maddr_next  = mem_addr;
		mwdata_next = mem_wdata;
		mwr_next    = 1'b0;
		mrd_next    = 1'b0;
		txp_next    = 1'b0;
		txw_next    = tx_word;
		rf_we       = 1'b0;
		rf_waddr    = opnd_reg.dst;
		rf_wdata    = 8'h00;

		// apb register access
		if (apb_acc) begin
			pready_next = 1'b1;
		end
		if (is_write) begin
			unique case (paddr)
				exec_pkg::CMD_OFS: begin
					if (state_reg == exec_pkg::ST_IDLE) begin
						cmd_next   = exec_pkg::cmd_s'(pwdata[19:0]);
						state_next = exec_pkg::ST_EXEC;
					end else begin
						pslverr_next = 1'b1;
					end
				end
				exec_pkg::OPND_OFS:    opnd_next = exec_pkg::opnd_s'(pwdata[17:0]);
				exec_pkg::FLAGS_OFS:   flags_next = exec_pkg::alu_flags_s'(pwdata[3:0]);
				exec_pkg::PTR1_OFS:    ptr_next[0] = pwdata[15:0];
				exec_pkg::PTR2_OFS:    ptr_next[1] = pwdata[15:0];
				exec_pkg::PTR3_OFS:    ptr_next[2] = pwdata[15:0];
				exec_pkg::PC_OFS:      pc_next = pwdata[15:0];
				exec_pkg::CONFIG_OFS:  cfg_next = pwdata[7:0];
				exec_pkg::IRQMASK_OFS: irqm_next = pwdata[7:0];
				exec_pkg::TXCTRL_OFS:  txhi_next = pwdata[2:0];
				default:               pslverr_next = 1'b1;
			endcase
		end else if (is_read && (paddr[7:6] == 2'b01 || paddr[7:6] == 2'b10)) begin
			prdata_next = {24'h000000, src_val};
		end else if (is_read) begin
			unique case (paddr)
				exec_pkg::CMD_OFS:     prdata_next = {12'h000, cmd_reg};
				exec_pkg::OPND_OFS:    prdata_next = {14'h0000, opnd_reg};
				exec_pkg::STATUS_OFS:  prdata_next = {24'h0, gate_reg, sp_reg, 1'b0, state_reg};
				exec_pkg::FLAGS_OFS:   prdata_next = {24'h0, flag_vec};
				exec_pkg::PTR1_OFS:    prdata_next = {16'h0, ptr_reg[0]};
				exec_pkg::PTR2_OFS:    prdata_next = {16'h0, ptr_reg[1]};
				exec_pkg::PTR3_OFS:    prdata_next = {16'h0, ptr_reg[2]};
				exec_pkg::PC_OFS:      prdata_next = {16'h0, pc_reg};
				exec_pkg::CONFIG_OFS:  prdata_next = {24'h0, cfg_reg};
				exec_pkg::IRQMASK_OFS: prdata_next = {24'h0, irqm_reg};
				exec_pkg::TXCTRL_OFS:  prdata_next = {29'h0, txhi_reg};
				default:               pslverr_next = 1'b1;
			endcase
		end

		// execution sequencer
		unique case (state_reg)
			exec_pkg::ST_IDLE: tcnt_next = 3'h0;
			exec_pkg::ST_EXEC: begin
				tcnt_next = 3'h1;
				unique case (exec_pkg::opcode_e'(cmd_reg.opcode))
					exec_pkg::OP_LOAD: tlen_next = cfg_reg[exec_pkg::CFG_LONG_READ_BIT] ?
						exec_pkg::T_LOAD_LONG : exec_pkg::T_LOAD_SHORT;
					exec_pkg::OP_MOVE_IMM, exec_pkg::OP_MOVE_REG, exec_pkg::OP_OR_ACC:
						tlen_next = cmd_reg.dst_mem ? exec_pkg::T_MEM_OP : exec_pkg::T_REG_OP;
					exec_pkg::OP_OR_IMM: tlen_next = exec_pkg::T_REG_OP;
					exec_pkg::OP_COND_RET: tlen_next = cond_true ?
						exec_pkg::T_RET_TAKEN : exec_pkg::T_RET_SKIP;
					default: tlen_next = exec_pkg::T_REG_OP;
				endcase
				if (cmd_reg.opcode == exec_pkg::OP_LOAD) begin
					maddr_next = eff_addr;
					mrd_next   = 1'b1;
				end
				state_next = exec_pkg::ST_WAIT;
			end
			exec_pkg::ST_WAIT: begin
				tcnt_next = 3'(tcnt_reg + 3'h1);
				if (tcnt_next == tlen_reg) begin
					state_next = exec_pkg::ST_IDLE;
					pc_next    = 16'(pc_reg + 16'h0001);
					unique case (exec_pkg::opcode_e'(cmd_reg.opcode))
						exec_pkg::OP_LOAD: begin
							rf_we    = 1'b1;
							rf_waddr = (cmd_reg.amode == exec_pkg::AM_PTR3_IMM) ? {1'b0, opnd_reg.dst[3:0]} : opnd_reg.dst;
							rf_wdata = mem_rdata;
						end
						exec_pkg::OP_MOVE_IMM, exec_pkg::OP_MOVE_REG, exec_pkg::OP_OR_ACC: begin
							if (cmd_reg.opcode == exec_pkg::OP_MOVE_IMM) begin
								rf_wdata = opnd_reg.imm;
							end else if (cmd_reg.opcode == exec_pkg::OP_MOVE_REG) begin
								rf_wdata = src_val;
							end else begin
								rf_wdata   = src_val | acc_val;
								flags_next = nz_flags(flags_reg, rf_wdata);
							end
							if (cmd_reg.dst_mem) begin
								maddr_next  = eff_addr;
								mwdata_next = rf_wdata;
								mwr_next    = 1'b1;
							end else begin
								rf_we    = 1'b1;
								rf_waddr = (cmd_reg.opcode == exec_pkg::OP_MOVE_IMM) ? {1'b0, opnd_reg.dst[3:0]} : opnd_reg.dst;
								if (opnd_reg.dst == 5'(TXPORT_REG)) begin
									txp_next = 1'b1;
									txw_next = {txhi_reg, rf_wdata};
								end
							end
						end
						exec_pkg::OP_OR_IMM: begin
							rf_we      = 1'b1;
							rf_waddr   = {1'b0, opnd_reg.dst[3:0]};
							rf_wdata   = src_val | opnd_reg.imm;
							flags_next = nz_flags(flags_reg, rf_wdata);
						end
						exec_pkg::OP_COND_RET: begin
							if (cond_true && sp_reg != 4'h0) begin
								pc_next = top.pc;
								sp_next = 4'(sp_reg - 4'd1);
								unique case (exec_pkg::gate_e'(cmd_reg.gate_op))
									exec_pkg::GATE_KEEP:    gate_next = gate_reg;
									exec_pkg::GATE_RESTORE: gate_next = top.gate;
									exec_pkg::GATE_SET:     gate_next = 1'b1;
									exec_pkg::GATE_CLEAR:   gate_next = 1'b0;
								endcase
								if (cmd_reg.restore_ctx) begin
									flags_next = top.flags;
									bank_next  = top.bank;
								end
							end
						end
						exec_pkg::OP_CALL: begin
							if (sp_reg != 4'(STACK_DEPTH)) begin
								stk_next[3'(sp_reg)] = '{pc: pc_next, flags: flags_reg, gate: gate_reg, bank: bank_reg};
								sp_next = 4'(sp_reg + 4'd1);
								pc_next = {opnd_reg.imm, 8'h00};
							end
						end
						default: ;
					endcase
					if (cmd_reg.amode == exec_pkg::AM_PTR_UPD && cmd_reg.upd != exec_pkg::UPD_NONE &&
						cmd_reg.opcode != exec_pkg::OP_COND_RET) begin
						ptr_next[psel_i] = ptr_inc;
					end
				end
			end
			default: state_next = exec_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers; ce low freezes everything
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= exec_pkg::ST_IDLE;
			cmd_reg   <= '0;
			opnd_reg  <= '0;
			flags_reg <= exec_pkg::FLAGS_RST[3:0];
			ptr_reg   <= '{default: exec_pkg::PTR_RST};
			pc_reg    <= 16'h0000;
			gate_reg  <= 1'b0;
			bank_reg  <= 4'h0;
			cfg_reg   <= 8'h00;
			irqm_reg  <= 8'h00;
			txhi_reg  <= 3'h0;
			tcnt_reg  <= 3'h0;
			tlen_reg  <= 3'h0;
			stk_reg   <= '{default: '0};
			sp_reg    <= 4'h0;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_wr    <= 1'b0;
			mem_rd    <= 1'b0;
			tx_push   <= 1'b0;
			tx_word   <= 11'h000;
		end else if (ce) begin
			state_reg <= state_next;
			cmd_reg   <= cmd_next;
			opnd_reg  <= opnd_next;
			flags_reg <= flags_next;
			ptr_reg   <= ptr_next;
			pc_reg    <= pc_next;
			gate_reg  <= gate_next;
			bank_reg  <= bank_next;
			cfg_reg   <= cfg_next;
			irqm_reg  <= irqm_next;
			txhi_reg  <= txhi_next;
			tcnt_reg  <= tcnt_next;
			tlen_reg  <= tlen_next;
			stk_reg   <= stk_next;
			sp_reg    <= sp_next;
			prdata    <= prdata_next;
			pready    <= pready_next;
			pslverr   <= pslverr_next;
			mem_addr  <= maddr_next;
			mem_wdata <= mwdata_next;
			mem_wr    <= mwr_next;
			mem_rd    <= mrd_next;
			tx_push   <= txp_next;
			tx_word   <= txw_next;
		end
	end

	// mask bits 1:0 gate only transmitter and receiver sources
	assign irq_mask_control = irqm_reg;
	assign global_irq_gate  = gate_reg;

endmodule : move_or_cond_return_exec

// ### exec_pkg.sv
// Purpose: shared constants and types for the move/or/conditional-return execution block
// Assumes: 8-bit data path, 16-bit data memory address, 16-bit program counter
// Notes:   register offsets are APB byte addresses
package exec_pkg;

	// ----------------------------------------
	// apb register map
	// ----------------------------------------
	localparam logic [7:0] CMD_OFS      = 8'h00;
	localparam logic [7:0] OPND_OFS     = 8'h04;
	localparam logic [7:0] STATUS_OFS   = 8'h08;
	localparam logic [7:0] FLAGS_OFS    = 8'h0C;
	localparam logic [7:0] PTR1_OFS     = 8'h10;
	localparam logic [7:0] PTR2_OFS     = 8'h14;
	localparam logic [7:0] PTR3_OFS     = 8'h18;
	localparam logic [7:0] PC_OFS       = 8'h1C;
	localparam logic [7:0] CONFIG_OFS   = 8'h20;
	localparam logic [7:0] IRQMASK_OFS  = 8'h24;
	localparam logic [7:0] TXCTRL_OFS   = 8'h28;
	localparam logic [7:0] REG_BASE_OFS = 8'h40;

	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int CFG_LONG_READ_BIT = 0;
	localparam int CFG_TIMING_W      = 3;
	localparam logic [7:0] IRQ_TXRX_MASK = 8'h03;
	localparam int TX_HI_W           = 3;

	// ----------------------------------------
	// reset values and timing counts (t-states)
	// ----------------------------------------
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [15:0] PTR_RST   = 16'h0000;
	localparam logic [2:0]  T_REG_OP      = 3'h2;
	localparam logic [2:0]  T_MEM_OP      = 3'h3;
	localparam logic [2:0]  T_LOAD_SHORT  = 3'h3;
	localparam logic [2:0]  T_LOAD_LONG   = 3'h4;
	localparam logic [2:0]  T_RET_SKIP    = 3'h2;
	localparam logic [2:0]  T_RET_TAKEN   = 3'h3;

	// ----------------------------------------
	// commands and modes
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_LOAD      = 4'h0,
		OP_MOVE_IMM  = 4'h1,
		OP_MOVE_REG  = 4'h2,
		OP_OR_IMM    = 4'h3,
		OP_OR_ACC    = 4'h4,
		OP_COND_RET  = 4'h5,
		OP_CALL      = 4'h6
	} opcode_e;

	typedef enum logic [1:0] {
		AM_REG       = 2'h0,
		AM_PTR_UPD   = 2'h1,
		AM_PTR_ACC   = 2'h2,
		AM_PTR3_IMM  = 2'h3
	} addr_mode_e;

	typedef enum logic [1:0] {
		UPD_NONE = 2'h0,
		UPD_POST = 2'h1,
		UPD_PRE  = 2'h2
	} upd_e;

	typedef enum logic [1:0] {
		GATE_KEEP    = 2'h0,
		GATE_RESTORE = 2'h1,
		GATE_SET     = 2'h2,
		GATE_CLEAR   = 2'h3
	} gate_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_WAIT = 2'b11
	} exec_state_e;

	// flags: bit0 zero, bit1 carry, bit2 overflow, bit3 negative
	typedef struct packed {
		logic n;
		logic v;
		logic c;
		logic z;
	} alu_flags_s;

	typedef struct packed {
		logic [15:0] pc;
		alu_flags_s  flags;
		logic        gate;
		logic [3:0]  bank;
	} stack_entry_s;

	// instruction word written through the command register
	typedef struct packed {
		logic [2:0] flag_sel;
		logic       flag_level;
		logic       gate_restore_src;
		logic [1:0] gate_op;
		logic       restore_ctx;
		logic [1:0] ptr_sel;
		logic [1:0] upd;
		logic [1:0] amode;
		logic       dst_mem;
		logic       unused;
		logic [3:0] opcode;
	} cmd_s;

	typedef struct packed {
		logic [7:0] imm;
		logic [4:0] src;
		logic [4:0] dst;
	} opnd_s;

endpackage : exec_pkg

// ### exec_regfile.sv
// Purpose: 32 x 8 register file with registered read
// Assumes: single write port, two read ports
// Notes:   read data appear one cycle after the address
`timescale 1ns/1ps
module exec_regfile #(
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          pclk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr_a,
	input  wire logic [AW-1:0] raddr_b,
	output logic      [7:0]    rdata_a,
	output logic      [7:0]    rdata_b
);

	logic [7:0] mem [DEPTH];

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata_a <= mem[raddr_a];
			rdata_b <= mem[raddr_b];
		end
	end

endmodule : exec_regfile

// ### exec_monitor.sv
// Purpose: port checks of the execution block
// Assumes: one clock, apb answer one cycle after the access is taken
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module exec_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mem_wr,
	input wire logic        mem_rd,
	input wire logic        tx_push,
	input wire logic [10:0] tx_word,
	input wire logic [7:0]  irq_mask_control
);
	// ----------------
	// helper state
	// ----------------
	logic       taken;
	logic [2:0] txhi_reg;
	logic [2:0] txhi_next;
	assign taken = psel && penable && !pready;
	// upper bits tracked here so a push can be judged without the body
	always_comb begin
		txhi_next = txhi_reg;
		if (taken && pwrite && paddr == exec_pkg::TXCTRL_OFS) txhi_next = pwdata[2:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) txhi_reg <= 3'h0;
		else txhi_reg <= txhi_next;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_follows: assert property (taken |=> pready)
		else $error("no answer after access");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	a_unmapped_refused: assert property (taken && paddr[7:6] == 2'h3 |=> pslverr)
		else $error("unmapped access accepted");
	a_irq_mask_write: assert property (taken && pwrite && paddr == exec_pkg::IRQMASK_OFS
		|=> ##1 irq_mask_control == $past(pwdata[7:0], 2)) else $error("mask not written");
	a_tx_upper_bits: assert property (tx_push |-> tx_word[10:8] == txhi_reg)
		else $error("push upper bits wrong");
	a_push_pulse: assert property (tx_push |=> !tx_push)
		else $error("push not a pulse");
	a_store_pulse: assert property (mem_wr |=> !mem_wr)
		else $error("store not a pulse");
	a_load_pulse: assert property (mem_rd |=> !mem_rd)
		else $error("load not a pulse");
	a_mem_exclusive: assert property (!(mem_rd && mem_wr))
		else $error("read and write together");
endmodule : exec_monitor
bind move_or_cond_return_exec exec_monitor u_exec_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .mem_wr, .mem_rd, .tx_push, .tx_word, .irq_mask_control);

// ### data_mem_model.sv
// Purpose: external data memory behind the pointer registers
// Assumes: writes land on the store pulse, reads answer after the load pulse
// Notes:   outside the read window data shows the inverse of the last byte
`timescale 1ns/1ps
module data_mem_model (
	input  wire logic        pclk,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic [1:0]  slow,
	output logic      [7:0]  mem_rdata
);
	// ----------------
	// storage
	// ----------------
	logic [7:0]  mem [0:65535];
	logic [15:0] last_a;
	logic [7:0]  last_d = 8'h5A;
	int          age = 99;
	always @(posedge pclk) begin
		age <= (mem_rd === 1'b1) ? 0 : age + 1;
		if (mem_wr === 1'b1) begin
			mem[mem_addr] <= mem_wdata;
			last_a <= mem_addr;
			last_d <= mem_wdata;
		end
	end
	// slow answers only suit the long read
	assign mem_rdata = (age >= slow && age < 8) ? mem[mem_addr] : ~last_d;
endmodule : data_mem_model

// ### move_or_cond_return_exec_test.sv
// Purpose: self-checking bench for the execution block
// Assumes: apb master tasks, bench register model, memory partner
// Notes:   completion is taken from the status poll
`timescale 1ns/1ps
module move_or_cond_return_exec_test;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er, fz, fn, g, tk;
	logic        mem_wr, mem_rd, tx_push, global_irq_gate;
	logic [7:0]  paddr, mem_wdata, mem_rdata, irq_mask_control, v, fv;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] mem_addr, a;
	logic [10:0] tx_word;
	logic [10:0] txq[$];
	logic [7:0]  m[32];
	logic [15:0] p[4];
	logic [3:0]  pins, r;
	logic [1:0]  slow;
	int          failures, n_tests, cyc, i, j, d;
	int          seed = 32'hB742;
	move_or_cond_return_exec u_move_or_cond_return_exec (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata,
		.receiver_active_flag(pins[0]), .line_error_flag(pins[1]), .receive_byte_ready(pins[2]),
		.transmit_queue_full(pins[3]), .tx_push, .tx_word, .irq_mask_control, .global_irq_gate);
	data_mem_model u_data_mem_model (.pclk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .slow, .mem_rdata);
	// ----------------
	// tasks
	// ----------------
	task automatic finish_test();
		if (failures == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] mk(input logic [3:0] op, input logic [6:0] mv, input logic [6:0] rt);
		exec_pkg::cmd_s c;
		c = '{rt[6:4], rt[3], 1'b0, rt[2:1], rt[0], mv[1:0], mv[3:2], mv[5:4], mv[6], 1'b0, op};
		return 32'(c);
	endfunction : mk
	task automatic run(input logic [31:0] c, input logic [7:0] im, input logic [4:0] s, input logic [4:0] dd);
		apb(1'b1, exec_pkg::OPND_OFS, {14'h0, im, s, dd});
		apb(1'b1, exec_pkg::CMD_OFS, c);
		do apb(1'b0, exec_pkg::STATUS_OFS, 32'h0); while (q[1:0] !== 2'h0);
	endtask : run
	task automatic rr(input int k);
		apb(1'b0, exec_pkg::REG_BASE_OFS + 8'(4 * k), 32'h0);
		chk(q[7:0], m[k]);
	endtask : rr
	task automatic fl();
		apb(1'b0, exec_pkg::FLAGS_OFS, 32'h0);
		chk(q[3:0], {fn, 2'b00, fz});
	endtask : fl
	task automatic nz(input logic [7:0] x);
		fz = (x == 8'h00);
		fn = x[7];
	endtask : nz
	task automatic st(input int s, input logic gg);
		apb(1'b0, exec_pkg::STATUS_OFS, 32'h0);
		chk(q[6:3], s);
		chk(q[7], gg);
		chk(global_irq_gate, gg);
	endtask : st
	task automatic call();
		run(mk(4'h6, 7'h00, 7'h00), 8'h12, 5'h00, 5'h00);
	endtask : call
	task automatic ret(input logic [2:0] fs, input logic lv, input logic [1:0] go, input logic rc);
		run(mk(4'h5, 7'h00, {fs, lv, go, rc}), 8'h00, 5'h00, 5'h00);
	endtask : ret
	// carry never sets here, so carry clear is always true
	task automatic gr(input logic [1:0] go, input int s, input logic ng);
		ret(3'h1, 1'b0, go, 1'b0);
		g = ng;
		st(s, g);
	endtask : gr
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (tx_push === 1'b1) txq.push_back(tx_word);
		if (cyc == 30000) begin
			failures++;
			finish_test();
		end
	end
	// ----------------
	// main sequence
	// ----------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn, pins, slow} = '0;
		{fz, fn, g} = '0;
		ce = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'hF0, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, exec_pkg::IRQMASK_OFS, 32'h3);
		@(negedge pclk);
		chk(irq_mask_control, 8'h03);
		for (i = 0; i < 31; i++) begin
			j = {$random(seed)} % ((i < 16) ? 16 : i);
			m[i] = (i < 16) ? 8'($random(seed)) : m[j];
			run(mk((i < 16) ? 4'h1 : 4'h2, 7'h00, 7'h00), m[i], 5'(j), 5'(i));
		end
		for (i = 0; i < 31; i++) rr(i);
		fl();
		run(mk(4'h1, 7'h00, 7'h00), 8'h00, 5'h00, 5'h05);
		m[5] = 8'h00;
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 5 : {$random(seed)} % 16;
			v = (i == 0) ? 8'h00 : 8'($random(seed));
			m[d] = m[d] | v;
			nz(m[d]);
			run(mk(4'h3, 7'h00, 7'h00), v, 5'h00, 5'(d));
			rr(d);
			fl();
			j = {$random(seed)} % 31;
			d = 1 + {$random(seed)} % 30;
			m[d] = m[j] | m[0];
			nz(m[d]);
			run(mk(4'h4, 7'h00, 7'h00), 8'h00, 5'(j), 5'(d));
			rr(d);
			fl();
		end
		apb(1'b1, exec_pkg::TXCTRL_OFS, 32'h5);
		for (i = 0; i < 2; i++) begin
			run(mk(i ? 4'h4 : 4'h2, 7'h00, 7'h00), 8'h00, 5'h03, 5'h1F);
			v = i ? m[3] | m[0] : m[3];
			if (i) nz(v);
			chk(txq.size(), 1);
			chk(txq.pop_front(), {3'h5, v});
		end
		p = '{16'h0000, 16'h1000, 16'h2000, 16'hFFFF};
		for (i = 1; i < 4; i++) apb(1'b1, exec_pkg::PTR1_OFS + 8'(4 * i - 4), p[i]);
		for (i = 1; i < 4; i++)
			for (j = 0; j < 3; j++) begin
				v = 8'($random(seed));
				run(mk(4'h1, {3'h5, 2'(j), 2'(i)}, 7'h00), v, 5'h00, 5'h00);
				if (j == 2) p[i]++;
				chk(u_data_mem_model.last_a, p[i]);
				chk(u_data_mem_model.last_d, v);
				if (j == 1) p[i]++;
				apb(1'b0, exec_pkg::PTR1_OFS + 8'(4 * i - 4), 32'h0);
				chk(q[15:0], p[i]);
			end
		p[3] = 16'hFFF8;
		apb(1'b1, exec_pkg::PTR3_OFS, p[3]);
		run(mk(4'h2, 7'h62, 7'h00), 8'h00, 5'h09, 5'h00);
		chk(u_data_mem_model.last_a, p[2] + 16'(m[0]));
		chk(u_data_mem_model.last_d, m[9]);
		run(mk(4'h4, 7'h73, 7'h00), 8'hF3, 5'h04, 5'h00);
		nz(m[4] | m[0]);
		chk(u_data_mem_model.last_a, 16'(p[3] + 16'h00F3));
		chk(u_data_mem_model.last_d, m[4] | m[0]);
		run(mk(4'h2, 7'h73, 7'h00), 8'h05, 5'h13, 5'h00);
		chk(u_data_mem_model.last_d, m[3]);
		for (i = 0; i < 3; i++) begin
			apb(1'b1, exec_pkg::CONFIG_OFS, 32'(i == 2));
			slow <= 2'(i == 2);
			a = (i == 0) ? p[1] : (i == 1) ? p[2] + 16'(m[0]) : p[3] + 16'h0021;
			v = 8'($random(seed));
			u_data_mem_model.mem[a] = v;
			m[6 + i] = v;
			run(mk(4'h0, {1'b0, 2'(i + 1), 2'h0, 2'(i + 1)}, 7'h00), 8'h21, 5'h00, 5'(6 + i));
			rr(6 + i);
		end
		fl();
		run(mk(4'h3, 7'h00, 7'h00), 8'h80, 5'h00, 5'h05);
		run(mk(4'h1, 7'h00, 7'h00), 8'h00, 5'h00, 5'h05);
		run(mk(4'h3, 7'h00, 7'h00), 8'h00, 5'h00, 5'h05);
		nz(8'h00);
		call();
		st(1, g);
		apb(1'b0, exec_pkg::PC_OFS, 32'h0);
		chk(q[15:0], 16'h1200);
		run(mk(4'h3, 7'h00, 7'h00), 8'h80, 5'h00, 5'h05);
		nz(8'h80);
		ret(3'h0, 1'b0, 2'h0, 1'b1);
		nz(8'h00);
		fl();
		st(0, g);
		call();
		gr(2'h2, 0, 1'b1);
		call();
		call();
		gr(2'h3, 1, 1'b0);
		gr(2'h1, 0, 1'b1);
		call();
		gr(2'h0, 0, 1'b1);
		call();
		gr(2'h3, 0, 1'b0);
		call();
		run(mk(4'h3, 7'h00, 7'h00), 8'h00, 5'h00, 5'h05);
		nz(8'h80);
		gr(2'h0, 0, 1'b0);
		fl();
		for (i = 0; i < 16; i++) begin
			r = 4'($random(seed));
			pins <= r;
			fv = {r, fn, 2'b00, fz};
			call();
			tk = (fv[i % 8] == (i >= 8));
			ret(3'(i % 8), 1'(i >= 8), 2'h0, 1'b0);
			st(tk ? 0 : 1, g);
			if (!tk) gr(2'h0, 0, g);
		end
		finish_test();
	end
endmodule : move_or_cond_return_exec_test
